// ==== design/sram_pkg.sv ====
// package: constants shared by the pipelined burst memory and its bench
// assumes: a 32-bit classic wishbone register port with byte addresses
package sram_pkg;
  // default geometry (wide variant: 512K x 36, narrow: 1M x 18)
  localparam int DATA_W_DEF = 36;
  localparam int ADDR_W_DEF = 19;
  localparam int LANES_DEF = 4;
  localparam int WIDE_WORDS = 524288;
  localparam int NARROW_WORDS = 1048576;
  localparam int BURST_W = 2;

  // register bus geometry
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] LAST_ADDR_OFF = 8'h08;
  localparam logic [7:0] RD_COUNT_OFF = 8'h0c;
  localparam logic [7:0] WR_COUNT_OFF = 8'h10;

  // control register fields and reset value
  localparam int CTRL_LINEAR_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // status register fields
  localparam int STAT_SEL_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_OFS_LSB = 2;
  localparam int STAT_KIND_LSB = 4;

  // counter reset value
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;

  // kind of access in the current cycle, gray along idle-read-write
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b11
  } acc_t;
endpackage : sram_pkg

// ==== design/burst_if.sv ====
// interface: carries burst load, step and order between datapath and sequencer
// assumes: both ends on the same clock
`timescale 1ns/1ns
interface burst_if;
  logic load;
  logic step;
  logic linear;
  logic [1:0] start;
  logic [1:0] offset;

  modport ctl (output load, output step, output linear, output start, input offset);
  modport seq (input load, input step, input linear, input start, output offset);
endinterface : burst_if

// ==== design/burst_seq.sv ====
// module: two-bit burst sequencer giving the low word offset of each access
// assumes: load and step come from registered inputs on the same clock
`timescale 1ns/1ns
module burst_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  burst_if.seq bus
);
  logic [1:0] start_q;
  logic [1:0] cnt_q;
  logic [1:0] start_now;
  logic [1:0] cnt_now;

  always_comb begin
    if (bus.load) begin
      start_now = bus.start;
      cnt_now = 2'h0;
    end else if (bus.step) begin
      start_now = start_q;
      cnt_now = cnt_q + 2'h1;
    end else begin
      start_now = start_q;
      cnt_now = cnt_q;
    end
  end

  assign bus.offset = bus.linear ? (start_now + cnt_now) : (start_now ^ cnt_now);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      start_q <= start_now;
      cnt_q <= cnt_now;
    end
  end
endmodule : burst_seq

// ==== design/burst_sram.sv ====
// module: synchronous pipelined burst memory with a wishbone control port
// assumes: the memory-bus controller runs on MCLK_I; output enable is asynchronous
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - every synchronous memory-bus input is captured in a register on the rising clock edge.
// - address and chip select load only when one of the two address strobes is active.
// - later burst addresses come from the internal counter, advancing only on burst_step.
// - the burst counter is two bits wide, so a burst spans four words from the loaded address.
// - burst order is interleaved or linear as chosen by the system.
// - a write registers address, data and controls, then completes on its own inside.
// - byte_lane_write with byte_write_master_enable picks which byte lanes are written.
// - global_write low writes every lane whatever the byte lane enables say.
// - output enable acts without a clock edge and is not captured; sleep is a control register bit written over wishbone.
// - a read returns its first word three clocks after the address and then one per clock.
// - deselect through the chip selects takes effect within one clock.
// - the array holds 512K words of 36 bits or 1M words of 18 bits.
// - the single-enable variant selects on chip_select_main alone.
module burst_sram #(
  parameter int DATA_W = sram_pkg::DATA_W_DEF,
  parameter int ADDR_W = sram_pkg::ADDR_W_DEF,
  parameter int LANES = sram_pkg::LANES_DEF,
  parameter bit THREE_CE = 1'b1
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  // memory bus
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE_O,
  input wire logic CHIP_SELECT_MAIN_N_I,
  input wire logic DEPTH_SELECT_A_I,
  input wire logic DEPTH_SELECT_B_N_I,
  input wire logic PROCESSOR_ADDR_STROBE_N_I,
  input wire logic CONTROLLER_ADDR_STROBE_N_I,
  input wire logic BURST_STEP_N_I,
  input wire logic [LANES-1:0] BYTE_LANE_WRITE_N_I,
  input wire logic BYTE_WRITE_MASTER_ENABLE_N_I,
  input wire logic GLOBAL_WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  // wishbone slave
  input wire logic [sram_pkg::WB_ADR_W-1:0] ADR_I,
  input wire logic [sram_pkg::WB_DAT_W-1:0] DAT_I,
  output logic [sram_pkg::WB_DAT_W-1:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;

  // captured memory-bus inputs
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] din_q;
  logic cs_main_n_q;
  logic cs_a_q;
  logic cs_b_n_q;
  logic ads_p_n_q;
  logic ads_c_n_q;
  logic step_n_q;
  logic [LANES-1:0] lane_n_q;
  logic master_n_q;
  logic global_n_q;

  // access state
  logic [ADDR_W-3:0] base_q;
  logic sel_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic ce_ok;
  logic load;
  logic sel_now;
  logic [ADDR_W-3:0] base_now;
  logic [ADDR_W-1:0] acc_addr;
  logic [LANES-1:0] lane_we;
  sram_pkg::acc_t kind;
  sram_pkg::acc_t kind_q;

  // storage and read pipeline
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [DATA_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] out_q;
  logic drive_q;

  // register file
  logic linear_q;
  logic sleep_q;
  logic [31:0] rd_count_q;
  logic [31:0] wr_count_q;
  logic ack_q;
  logic [sram_pkg::WB_DAT_W-1:0] dat_q;
  logic wb_req;
  logic wb_wr;

  burst_if bif ();

  burst_seq u_seq (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .bus(bif.seq)
  );

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      addr_q <= '0;
      din_q <= '0;
      cs_main_n_q <= 1'b1;
      cs_a_q <= 1'b0;
      cs_b_n_q <= 1'b1;
      ads_p_n_q <= 1'b1;
      ads_c_n_q <= 1'b1;
      step_n_q <= 1'b1;
      lane_n_q <= '1;
      master_n_q <= 1'b1;
      global_n_q <= 1'b1;
    end else begin
      addr_q <= ADDR_I;
      din_q <= DQ_I;
      cs_main_n_q <= CHIP_SELECT_MAIN_N_I;
      cs_a_q <= DEPTH_SELECT_A_I;
      cs_b_n_q <= DEPTH_SELECT_B_N_I;
      ads_p_n_q <= PROCESSOR_ADDR_STROBE_N_I;
      ads_c_n_q <= CONTROLLER_ADDR_STROBE_N_I;
      step_n_q <= BURST_STEP_N_I;
      lane_n_q <= BYTE_LANE_WRITE_N_I;
      master_n_q <= BYTE_WRITE_MASTER_ENABLE_N_I;
      global_n_q <= GLOBAL_WRITE_N_I;
    end
  end

  // single-enable variant ignores the depth selects
  assign ce_ok = THREE_CE ? (!cs_main_n_q && cs_a_q && !cs_b_n_q) : !cs_main_n_q;

  // load on either strobe; processor strobe is ignored while main select is high
  assign load = !sleep_q && (!ads_c_n_q || (!ads_p_n_q && !cs_main_n_q));

  // deselect takes effect in the load cycle itself
  assign sel_now = load ? ce_ok : sel_q;
  assign base_now = load ? addr_q[ADDR_W-1:2] : base_q;

  // burst sequencer controls
  assign bif.load = load;
  assign bif.start = addr_q[1:0];
  assign bif.linear = linear_q;
  assign bif.step = !load && !step_n_q && sel_q && !sleep_q;

  // upper bits held, low two bits from the counter
  assign acc_addr = {base_now, bif.offset};

  always_comb begin
    if (!global_n_q) begin
      lane_we = '1;
    end else if (!master_n_q) begin
      lane_we = ~lane_n_q;
    end else begin
      lane_we = '0;
    end
  end

  // classify the current cycle; a processor-strobe load is never a write
  always_comb begin
    if (!sel_now || sleep_q) begin
      kind = sram_pkg::ACC_IDLE;
    end else if ((lane_we != '0) && !(load && !ads_p_n_q)) begin
      kind = sram_pkg::ACC_WRITE;
    end else begin
      kind = sram_pkg::ACC_READ;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      base_q <= '0;
      sel_q <= 1'b0;
      last_addr_q <= '0;
      kind_q <= sram_pkg::ACC_IDLE;
    end else begin
      base_q <= base_now;
      sel_q <= sel_now && !sleep_q;
      kind_q <= kind;
      if (load) begin
        last_addr_q <= addr_q;
      end
    end
  end

  // self-timed write from the captured word
  // array sized by the address width
  always_ff @(posedge MCLK_I) begin
    if (kind == sram_pkg::ACC_WRITE) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[acc_addr][i*LANE_W +: LANE_W] <= din_q[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // array stage of the read pipeline
  always_ff @(posedge MCLK_I) begin
    rd_data_q <= mem[acc_addr];
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_valid_q <= 1'b0;
      out_q <= '0;
      drive_q <= 1'b0;
    end else begin
      rd_valid_q <= (kind == sram_pkg::ACC_READ);
      drive_q <= rd_valid_q;
      if (rd_valid_q) begin
        out_q <= rd_data_q;
      end
    end
  end

  assign DQ_O = out_q;
  // asynchronous output enable and sleep gate the drive
  assign DQ_OE_O = drive_q && !OUTPUT_ENABLE_N_I && !sleep_q;

  // wishbone request decode
  assign wb_req = CYC_I && STB_I && !ack_q;
  assign wb_wr = wb_req && WE_I;

  // order select and sleep request held in control
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      linear_q <= sram_pkg::CTRL_RST[sram_pkg::CTRL_LINEAR_BIT];
      sleep_q <= sram_pkg::CTRL_RST[sram_pkg::CTRL_SLEEP_BIT];
    end else if (wb_wr && (ADR_I == sram_pkg::CTRL_OFF) && SEL_I[0]) begin
      linear_q <= DAT_I[sram_pkg::CTRL_LINEAR_BIT];
      sleep_q <= DAT_I[sram_pkg::CTRL_SLEEP_BIT];
    end
  end

  // access counters; a count in the clearing cycle is kept
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_count_q <= sram_pkg::COUNT_RST;
      wr_count_q <= sram_pkg::COUNT_RST;
    end else begin
      if (wb_wr && (ADR_I == sram_pkg::RD_COUNT_OFF)) begin
        rd_count_q <= (kind == sram_pkg::ACC_READ) ? 32'h0000_0001 : 32'h0000_0000;
      end else if (kind == sram_pkg::ACC_READ) begin
        rd_count_q <= rd_count_q + 32'h0000_0001;
      end
      if (wb_wr && (ADR_I == sram_pkg::WR_COUNT_OFF)) begin
        wr_count_q <= (kind == sram_pkg::ACC_WRITE) ? 32'h0000_0001 : 32'h0000_0000;
      end else if (kind == sram_pkg::ACC_WRITE) begin
        wr_count_q <= wr_count_q + 32'h0000_0001;
      end
    end
  end

  // wishbone answer: ack one cycle after the strobe, read data with it
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !WE_I) begin
        case (ADR_I)
          sram_pkg::CTRL_OFF: begin
            dat_q <= {30'h0, sleep_q, linear_q};
          end
          sram_pkg::STATUS_OFF: begin
            dat_q <= {26'h0, kind_q, bif.offset, sleep_q, sel_q};
          end
          sram_pkg::LAST_ADDR_OFF: begin
            dat_q <= 32'(last_addr_q);
          end
          sram_pkg::RD_COUNT_OFF: begin
            dat_q <= rd_count_q;
          end
          sram_pkg::WR_COUNT_OFF: begin
            dat_q <= wr_count_q;
          end
          default: begin
            dat_q <= 32'h0000_0000;
          end
        endcase
      end else begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;
endmodule : burst_sram

// ==== test/burst_sram_sva.sv ====
// checker: read drive timing, deselect and register port handshake
// assumes: bound into burst_sram, single clock MCLK_I
`timescale 1ns/1ns
module burst_sram_sva (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic DQ_OE_O,
  input wire logic CHIP_SELECT_MAIN_N_I,
  input wire logic PROCESSOR_ADDR_STROBE_N_I,
  input wire logic CONTROLLER_ADDR_STROBE_N_I,
  input wire logic BURST_STEP_N_I,
  input wire logic BYTE_WRITE_MASTER_ENABLE_N_I,
  input wire logic GLOBAL_WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // selected controller load, and drive expected unless output disabled
  wire ld = !CHIP_SELECT_MAIN_N_I && !CONTROLLER_ADDR_STROBE_N_I;
  wire drv = OUTPUT_ENABLE_N_I || DQ_OE_O;
  sequence rd_load;
    ld && GLOBAL_WRITE_N_I && BYTE_WRITE_MASTER_ENABLE_N_I;
  endsequence
  sequence stepping;
    CONTROLLER_ADDR_STROBE_N_I && PROCESSOR_ADDR_STROBE_N_I && !BURST_STEP_N_I;
  endsequence
  first_word_a: assert property (rd_load |-> ##3 drv)
    else $error("first read word not driven");
  burst_words_a: assert property (rd_load ##1 stepping [*2] |-> ##1 drv [*3])
    else $error("burst words not driven");
  proc_load_a: assert property (!CHIP_SELECT_MAIN_N_I && !PROCESSOR_ADDR_STROBE_N_I |-> ##3 drv)
    else $error("processor strobe read not driven");
  deselect_quiet_a: assert property (CHIP_SELECT_MAIN_N_I && !CONTROLLER_ADDR_STROBE_N_I |-> ##3 !DQ_OE_O)
    else $error("drive after deselect");
  write_quiet_a: assert property (ld && !GLOBAL_WRITE_N_I |-> ##3 !DQ_OE_O)
    else $error("drive for a write");
  oe_gate_a: assert property (OUTPUT_ENABLE_N_I |-> !DQ_OE_O)
    else $error("drive with output disabled");
  ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
endmodule : burst_sram_sva
bind burst_sram burst_sram_sva chk_inst (.MCLK_I, .RST_I, .DQ_OE_O, .CHIP_SELECT_MAIN_N_I,
  .PROCESSOR_ADDR_STROBE_N_I, .CONTROLLER_ADDR_STROBE_N_I, .BURST_STEP_N_I,
  .BYTE_WRITE_MASTER_ENABLE_N_I, .GLOBAL_WRITE_N_I, .OUTPUT_ENABLE_N_I, .CYC_I, .STB_I, .ACK_O);

// ==== test/mem_ctl_model.sv ====
// model: cache controller driving the memory bus
// assumes: shares the memory clock; reads answer three edges after load
`timescale 1ns/1ns
module mem_ctl_model #(parameter int AW = 8, parameter int DW = 36) (
  input wire logic clk_i,
  input wire logic [DW-1:0] dq_i,
  input wire logic oe_i,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] dq_o,
  output logic cs_n_o,
  output logic dsa_o,
  output logic dsb_n_o,
  output logic ps_n_o,
  output logic cts_n_o,
  output logic step_n_o,
  output logic [3:0] lane_n_o,
  output logic bwe_n_o,
  output logic gw_n_o,
  output logic oe_n_o
);
  // idle bus: selected, no strobe, no write
  initial begin
    {addr_o, dq_o, cs_n_o, dsb_n_o, oe_n_o} = '0;
    {dsa_o, ps_n_o, cts_n_o, step_n_o, lane_n_o, bwe_n_o, gw_n_o} = '1;
  end
  // one write cycle on the controller strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] ln,
                    input logic bw, input logic g);
    @(posedge clk_i);
    addr_o <= a;
    dq_o <= d;
    cts_n_o <= 1'b0;
    lane_n_o <= ln;
    bwe_n_o <= bw;
    gw_n_o <= g;
    @(posedge clk_i);
    {cts_n_o, bwe_n_o, gw_n_o} <= 3'h7;
    dq_o <= ~d; // released data no longer valid
  endtask : wr
  // load, step three times, collect four words with drive flag
  task automatic rd(input logic [AW-1:0] a, input bit p, input bit cs, input bit off,
                    output logic [DW:0] w [4]);
    @(posedge clk_i);
    addr_o <= a;
    cs_n_o <= !cs;
    ps_n_o <= !p;
    cts_n_o <= p;
    oe_n_o <= off;
    @(posedge clk_i);
    {ps_n_o, cts_n_o, step_n_o} <= 3'h6;
    addr_o <= ~a;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      w[i] = {oe_i, dq_i};
      step_n_o <= 1'b1;
    end
    cs_n_o <= 1'b0;
    oe_n_o <= 1'b0;
  endtask : rd
endmodule : mem_ctl_model

// ==== test/burst_sram_bench.sv ====
// bench: random lane writes, bursts in both orders, register port checks
// assumes: design and model compiled first
`timescale 1ns/1ns
module burst_sram_bench;
  localparam int AW = 8;
  localparam int DW = 36;
  logic mclk, rst, we, cyc, stb, ack, dq_oe, cs_n, dsa, dsb_n, ps_n, cts_n, step_n;
  logic bwe_n, gw_n, oe_n, bw, g, lin;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel, lane_n, ln;
  logic [AW-1:0] addr, base;
  logic [DW-1:0] dq_w, dq_r, d;
  logic [DW-1:0] mem [2**AW];
  logic [DW:0] w [4];
  logic [1:0] s, o;
  int it, k, i, error_cnt, n_tests, cycles;
  burst_sram #(.ADDR_W(AW)) burst_sram_inst (
    .MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .DQ_I(dq_w), .DQ_O(dq_r), .DQ_OE_O(dq_oe),
    .CHIP_SELECT_MAIN_N_I(cs_n), .DEPTH_SELECT_A_I(dsa), .DEPTH_SELECT_B_N_I(dsb_n),
    .PROCESSOR_ADDR_STROBE_N_I(ps_n), .CONTROLLER_ADDR_STROBE_N_I(cts_n),
    .BURST_STEP_N_I(step_n), .BYTE_LANE_WRITE_N_I(lane_n),
    .BYTE_WRITE_MASTER_ENABLE_N_I(bwe_n), .GLOBAL_WRITE_N_I(gw_n), .OUTPUT_ENABLE_N_I(oe_n),
    .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc),
    .STB_I(stb), .ACK_O(ack));
  mem_ctl_model #(.AW(AW)) mem_ctl_model_inst (
    .clk_i(mclk), .dq_i(dq_r), .oe_i(dq_oe), .addr_o(addr), .dq_o(dq_w), .cs_n_o(cs_n),
    .dsa_o(dsa), .dsb_n_o(dsb_n), .ps_n_o(ps_n), .cts_n_o(cts_n), .step_n_o(step_n),
    .lane_n_o(lane_n), .bwe_n_o(bwe_n), .gw_n_o(gw_n), .oe_n_o(oe_n));
  // word after a write: global write takes all lanes, else enabled lanes
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] n);
    for (int j = 0; j < 4; j++)
      if (!g || (!bw && !ln[j])) o[j*9 +: 9] = n[j*9 +: 9];
    return o;
  endfunction : merge
  task automatic chk(string nm, logic [63:0] e, logic [63:0] v);
    n_tests++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w_e, input logic [7:0] a, input logic [31:0] dd);
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w_e, a, dd, 4'hf};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    rst = 1;
    cycles = 0;
    {cyc, stb, we, adr, wdat, sel} = '0;
    void'($urandom(32'he56c));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    wb(0, sram_pkg::CTRL_OFF, 0);
    chk("ctrl", sram_pkg::CTRL_RST, q);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, q);
    wb(1, sram_pkg::CTRL_OFF, 32'h2);
    wb(0, sram_pkg::STATUS_OFF, 0);
    chk("sleep", 1, q[sram_pkg::STAT_SLEEP_BIT]);
    wb(1, sram_pkg::CTRL_OFF, 0);
    for (it = 0; it < 30; it++) begin
      base = AW'($urandom) & 8'hfc;
      {g, bw, ln} = 6'h0f;
      for (k = 0; k < 4; k++) begin
        d = DW'({$urandom, $urandom});
        mem_ctl_model_inst.wr(base + AW'(k), d, ln, bw, g);
        mem[base + AW'(k)] = d;
      end
      // random lanes, master enable and global write
      k = $urandom % 4;
      d = DW'({$urandom, $urandom});
      {g, bw, ln} = 6'($urandom);
      mem_ctl_model_inst.wr(base + AW'(k), d, ln, bw, g);
      mem[base + AW'(k)] = merge(mem[base + AW'(k)], d);
      lin = 1'($urandom);
      wb(1, sram_pkg::CTRL_OFF, {31'h0, lin});
      s = 2'($urandom);
      mem_ctl_model_inst.rd(base | AW'(s), it % 6 == 1, it % 7 != 3, it % 5 == 4, w);
      // every strobe load records its address, selected or not
      wb(0, sram_pkg::LAST_ADDR_OFF, 0);
      chk("last addr", base | AW'(s), q);
      for (i = 0; i < 4; i++) begin
        o = lin ? s + 2'(i) : s ^ 2'(i);
        if (it % 7 != 3 && it % 5 != 4)
          chk("word", {1'b1, mem[base | AW'(o)]}, w[i]);
        else
          chk("drive", 0, w[i][DW]);
      end
    end
    conclude();
  end
endmodule : burst_sram_bench
